// ---- chromaticity_readback.sv ----
// Behaviour
// - 73h returns white x bits 9..2
// - 74h returns white y bits 9..2
// - 75h returns red/green low bit pairs
// - 76h returns red x bits 9..2
// - 77h returns red y bits 9..2
// - 7Ah returns blue/A low bit pairs
// - 7Bh returns blue x bits 9..2
// - served unless partial display mode active
// - unprogrammed memory reads 00h after reset
// - command alone, exactly one byte answered
`timescale 1ns/1ps
`include "chroma_defines.svh"
module chromaticity_readback #(
	parameter int COORD_W = 10,
	parameter int N_COORD = 11
) (
	input  wire logic                       clk_sys_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       cmd_valid_in,
	input  wire logic [7:0]                 cmd_code_in,
	input  wire logic                       cmd_has_param_in,
	input  wire logic                       partial_mode_in,
	input  wire logic                       otp_load_in,
	input  wire logic [N_COORD*COORD_W-1:0] otp_data_in,
	output logic                            resp_valid_out,
	output logic [7:0]                      resp_data_out,
	output logic                            cmd_reject_out
);
	generate
		if (COORD_W != 10 || N_COORD != 11) begin : g_bad_layout
			$error("chromaticity_readback: layout fixed at 11 coords of 10 bits");
		end
	endgenerate

	coord_store_if #(.COORD_W(COORD_W), .N_COORD(N_COORD)) store_bus ();

	coord_store #(
		.COORD_W(COORD_W),
		.N_COORD(N_COORD)
	) u_store (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.otp_load_in (otp_load_in),
		.otp_data_in (otp_data_in),
		.st          (store_bus.store)
	);

	chroma_pkg::resp_state_t state;
	logic [7:0]              cmd_hold;
	logic [7:0]              next_data;
	logic                    next_known;

	function automatic logic [7:0] upper(input logic [COORD_W-1:0] c);
		return c[`COORD_UPPER_MSB:`COORD_UPPER_LSB];
	endfunction

	function automatic logic [1:0] low(input logic [COORD_W-1:0] c);
		return c[1:0];
	endfunction

	// zero until the first load, whatever the store holds
	logic [COORD_W-1:0] live [N_COORD];
	logic [COORD_W-1:0] black_y_coord;
	logic [COORD_W-1:0] white_x_coord;
	logic [COORD_W-1:0] white_y_coord;
	logic [COORD_W-1:0] red_x_coord;
	logic [COORD_W-1:0] red_y_coord;
	logic [COORD_W-1:0] green_x_coord;
	logic [COORD_W-1:0] green_y_coord;
	logic [COORD_W-1:0] blue_x_coord;
	logic [COORD_W-1:0] blue_y_coord;
	logic [COORD_W-1:0] colour_a_x_coord;
	logic [COORD_W-1:0] colour_a_y_coord;

	always_comb begin
		for (int i = 0; i < N_COORD; i++) begin
			live[i] = store_bus.programmed ? store_bus.coord[i] : '0;
		end
	end

	assign black_y_coord    = live[chroma_pkg::COORD_BLACK_Y];
	assign white_x_coord    = live[chroma_pkg::COORD_WHITE_X];
	assign white_y_coord    = live[chroma_pkg::COORD_WHITE_Y];
	assign red_x_coord      = live[chroma_pkg::COORD_RED_X];
	assign red_y_coord      = live[chroma_pkg::COORD_RED_Y];
	assign green_x_coord    = live[chroma_pkg::COORD_GREEN_X];
	assign green_y_coord    = live[chroma_pkg::COORD_GREEN_Y];
	assign blue_x_coord     = live[chroma_pkg::COORD_BLUE_X];
	assign blue_y_coord     = live[chroma_pkg::COORD_BLUE_Y];
	assign colour_a_x_coord = live[chroma_pkg::COORD_A_X];
	assign colour_a_y_coord = live[chroma_pkg::COORD_A_Y];

	logic [7:0] black_y_upper;
	logic [7:0] white_x_upper;
	logic [7:0] white_y_upper;
	logic [7:0] red_green_low_pairs;
	logic [7:0] red_x_upper;
	logic [7:0] red_y_upper;
	logic [7:0] green_x_upper;
	logic [7:0] green_y_upper;
	logic [7:0] blue_a_low_pairs;
	logic [7:0] blue_x_upper;

	assign black_y_upper = upper(black_y_coord);
	assign white_x_upper = upper(white_x_coord);
	assign white_y_upper = upper(white_y_coord);
	assign red_green_low_pairs = {low(red_x_coord), low(red_y_coord),
		low(green_x_coord), low(green_y_coord)};
	assign red_x_upper   = upper(red_x_coord);
	assign red_y_upper   = upper(red_y_coord);
	assign green_x_upper = upper(green_x_coord);
	assign green_y_upper = upper(green_y_coord);
	assign blue_a_low_pairs = {low(blue_x_coord), low(blue_y_coord),
		low(colour_a_x_coord), low(colour_a_y_coord)};
	assign blue_x_upper  = upper(blue_x_coord);

	// pure lookup: nothing here writes the store or any mode
	always_comb begin
		next_data  = `UNPROGRAMMED_VALUE;
		next_known = 1'b1;
		case (cmd_hold)
			`CMD_READ_BLACK_Y:       next_data = black_y_upper;
			`CMD_READ_WHITE_X:       next_data = white_x_upper;
			`CMD_READ_WHITE_Y:       next_data = white_y_upper;
			`CMD_READ_RED_GREEN_LOW: next_data = red_green_low_pairs;
			`CMD_READ_RED_X:         next_data = red_x_upper;
			`CMD_READ_RED_Y:         next_data = red_y_upper;
			`CMD_READ_GREEN_X:       next_data = green_x_upper;
			`CMD_READ_GREEN_Y:       next_data = green_y_upper;
			`CMD_READ_BLUE_A_LOW:    next_data = blue_a_low_pairs;
			`CMD_READ_BLUE_X:        next_data = blue_x_upper;
			default:                 next_known = 1'b0;
		endcase
	end

	function automatic logic is_ours(input logic [7:0] c);
		return (c >= `CMD_READ_BLACK_Y) && (c <= `CMD_READ_BLUE_X);
	endfunction

	logic cmd_ours;
	logic cmd_clean;
	logic take_cmd;
	logic refuse_cmd;

	assign cmd_ours   = cmd_valid_in && is_ours(cmd_code_in);
	assign cmd_clean  = !cmd_has_param_in && !partial_mode_in;
	assign take_cmd   = state == chroma_pkg::ST_IDLE && cmd_ours && cmd_clean;
	assign refuse_cmd = state == chroma_pkg::ST_IDLE && cmd_ours && !cmd_clean;

	// commands outside our range are left to other responders
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state <= chroma_pkg::ST_IDLE;
		end else begin
			case (state)
				chroma_pkg::ST_IDLE: begin
					if (take_cmd) begin
						state <= chroma_pkg::ST_TAKEN;
					end
				end
				chroma_pkg::ST_TAKEN: state <= chroma_pkg::ST_ANSWER;
				chroma_pkg::ST_ANSWER: state <= chroma_pkg::ST_IDLE;
				default: state <= chroma_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cmd_hold <= 8'h00;
		end else if (state == chroma_pkg::ST_IDLE && cmd_valid_in) begin
			cmd_hold <= cmd_code_in;
		end
	end

	// exactly one byte per accepted read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			resp_valid_out <= 1'b0;
			resp_data_out  <= 8'h00;
		end else if (state == chroma_pkg::ST_TAKEN && next_known) begin
			resp_valid_out <= 1'b1;
			resp_data_out  <= next_data;
		end else begin
			resp_valid_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cmd_reject_out <= 1'b0;
		end else begin
			cmd_reject_out <= refuse_cmd;
		end
	end
endmodule // chromaticity_readback

// ---- chroma_defines.svh ----
`ifndef CHROMA_DEFINES_SVH
`define CHROMA_DEFINES_SVH

`define CMD_READ_BLACK_Y      8'h72
`define CMD_READ_WHITE_X      8'h73
`define CMD_READ_WHITE_Y      8'h74
`define CMD_READ_RED_GREEN_LOW 8'h75
`define CMD_READ_RED_X        8'h76
`define CMD_READ_RED_Y        8'h77
`define CMD_READ_GREEN_X      8'h78
`define CMD_READ_GREEN_Y      8'h79
`define CMD_READ_BLUE_A_LOW   8'h7A
`define CMD_READ_BLUE_X       8'h7B
`define UNPROGRAMMED_VALUE    8'h00
`define COORD_UPPER_MSB       9
`define COORD_UPPER_LSB       2

`endif

// ---- chroma_pkg.sv ----
package chroma_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_TAKEN = 2'b01,
		ST_ANSWER = 2'b11
	} resp_state_t;

	typedef enum logic [3:0] {
		COORD_BLACK_Y = 4'h0,
		COORD_WHITE_X = 4'h1,
		COORD_WHITE_Y = 4'h2,
		COORD_RED_X   = 4'h3,
		COORD_RED_Y   = 4'h4,
		COORD_GREEN_X = 4'h5,
		COORD_GREEN_Y = 4'h6,
		COORD_BLUE_X  = 4'h7,
		COORD_BLUE_Y  = 4'h8,
		COORD_A_X     = 4'h9,
		COORD_A_Y     = 4'hA
	} coord_sel_t;
endpackage

// ---- coord_store_if.sv ----
`timescale 1ns/1ps
interface coord_store_if #(parameter int COORD_W = 10, parameter int N_COORD = 11);
	logic [COORD_W-1:0] coord [N_COORD];
	logic               programmed;
	modport store (output coord, output programmed);
	modport user  (input coord, input programmed);
endinterface

// ---- coord_store.sv ----
`timescale 1ns/1ps
`include "chroma_defines.svh"
module coord_store #(
	parameter int COORD_W = 10,
	parameter int N_COORD = 11
) (
	input  wire logic                       clk_sys_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       otp_load_in,
	input  wire logic [N_COORD*COORD_W-1:0] otp_data_in,
	coord_store_if.store                    st
);
	// one-time memory image; once loaded, held over every reset after the first, zero before
	logic [COORD_W-1:0] image [N_COORD];
	logic               loaded;
	// only the first reset after power-up may clear the image
	logic               por_done = 1'b0;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in && !por_done) begin
			loaded <= 1'b0;
		end else if (otp_load_in) begin
			loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in && !por_done) begin
			por_done <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < N_COORD; i++) begin
			if (!rst_n_in && !por_done) begin
				image[i] <= '0;
			end else if (otp_load_in && !loaded) begin
				image[i] <= otp_data_in[i*COORD_W +: COORD_W];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_COORD; i++) begin
			st.coord[i] = image[i];
		end
		st.programmed = loaded;
	end
endmodule // coord_store

// ---- chroma_properties.sv ----
`timescale 1ns/1ps
module chroma_checker #(parameter int COORD_W = 10, parameter int N_COORD = 11) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic cmd_has_param_in,
	input wire logic partial_mode_in,
	input wire logic otp_load_in,
	input wire logic [N_COORD*COORD_W-1:0] otp_data_in,
	input wire logic resp_valid_out,
	input wire logic [7:0] resp_data_out,
	input wire logic cmd_reject_out
);
	logic [1:0] bsy;
	logic prog = 1'b0;
	wire ask = cmd_valid_in && bsy == 2'h0 && cmd_code_in inside {[8'h72:8'h7B]};
	wire acc = ask && !cmd_has_param_in && !partial_mode_in;
	wire refuse = ask && !acc;
	// no reset here: the image outlives every reset after the first one
	always_ff @(posedge clk_sys_in) if (otp_load_in) prog <= 1'b1;
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in) bsy <= 2'h0;
		else if (bsy != 2'h0) bsy <= bsy - 2'h1;
		else if (acc) bsy <= 2'h2;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_ans_lag: assert property (acc |-> ##2 resp_valid_out) else $error("late");
	a_ans_cause: assert property (resp_valid_out |-> $past(acc, 2)) else $error("stray");
	a_ans_once: assert property (resp_valid_out |=> !resp_valid_out) else $error("long");
	a_data_holds: assert property (!resp_valid_out |-> $stable(resp_data_out)) else $error("moved");
	a_blank_zero: assert property (resp_valid_out && !prog |-> resp_data_out == 8'h00)
		else $error("blank");
	a_param_refused: assert property (refuse && cmd_has_param_in |=> cmd_reject_out)
		else $error("param");
	a_mode_refused: assert property (refuse && partial_mode_in |=> cmd_reject_out)
		else $error("partial");
	a_rej_cause: assert property (cmd_reject_out |-> $past(refuse)) else $error("reject");
endmodule // chroma_checker
bind chromaticity_readback chroma_checker #(
	.COORD_W(COORD_W),
	.N_COORD(N_COORD)
) u_chk (
	.clk_sys_in       (clk_sys_in),
	.rst_n_in         (rst_n_in),
	.cmd_valid_in     (cmd_valid_in),
	.cmd_code_in      (cmd_code_in),
	.cmd_has_param_in (cmd_has_param_in),
	.partial_mode_in  (partial_mode_in),
	.otp_load_in      (otp_load_in),
	.otp_data_in      (otp_data_in),
	.resp_valid_out   (resp_valid_out),
	.resp_data_out    (resp_data_out),
	.cmd_reject_out   (cmd_reject_out)
);

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model (
	input  wire logic  clk_sys_in,
	output logic       cmd_valid_out,
	output logic       cmd_has_param_out,
	output logic [7:0] cmd_code_out
);
	initial cmd_valid_out = 1'b0;
	initial cmd_has_param_out = 1'b0;
	initial cmd_code_out = 8'h00;
	// one lone strobe; code and flag turn to junk once released
	task automatic send(input logic [7:0] c, input logic p);
		@(negedge clk_sys_in);
		cmd_valid_out = 1'b1;
		cmd_code_out = c;
		cmd_has_param_out = p;
		@(negedge clk_sys_in);
		cmd_valid_out = 1'b0;
		cmd_code_out = ~c;
		cmd_has_param_out = ~p;
	endtask
	// full coordinate is the upper byte over its low pair
	function automatic logic [9:0] join_coord(input logic [7:0] up, input logic [1:0] pair);
		return {up, pair};
	endfunction
endmodule // host_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic         clk_sys_in = 1'b0;
	logic         rst_n_in = 1'b0;
	logic         partial_mode_in = 1'b0;
	logic         otp_load_in = 1'b0;
	logic         cmd_valid_in, cmd_has_param_in, resp_valid_out, cmd_reject_out;
	logic [7:0]   cmd_code_in, resp_data_out;
	logic [109:0] otp_data_in;
	logic [7:0]   last_ans = 8'h00;
	logic [7:0]   low_ans = 8'h00;
	int           n_mismatch = 0;
	int           n_compared = 0;
	// coord i = {11h*(i+1), (i/2)[1:0]}; bytes for 72h..7Bh
	logic [7:0]   exp_t [10] = '{8'h11, 8'h22, 8'h33, 8'h6B, 8'h44, 8'h55, 8'h66, 8'h77, 8'hC1, 8'h88};
	chromaticity_readback u_dut (
		.clk_sys_in       (clk_sys_in),
		.rst_n_in         (rst_n_in),
		.cmd_valid_in     (cmd_valid_in),
		.cmd_code_in      (cmd_code_in),
		.cmd_has_param_in (cmd_has_param_in),
		.partial_mode_in  (partial_mode_in),
		.otp_load_in      (otp_load_in),
		.otp_data_in      (otp_data_in),
		.resp_valid_out   (resp_valid_out),
		.resp_data_out    (resp_data_out),
		.cmd_reject_out   (cmd_reject_out)
	);
	host_model u_host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid_in),
		.cmd_has_param_out(cmd_has_param_in), .cmd_code_out(cmd_code_in));
	task automatic rd(input logic [7:0] c, input logic p, input logic [7:0] e,
		input logic eok, input logic erj);
		logic ok, rj;
		ok = 1'b0;
		rj = 1'b0;
		u_host.send(c, p);
		// reject stands in the cycle after the take edge, the answer one cycle later
		repeat (3) begin
			if (resp_valid_out === 1'b1 && resp_data_out === e) ok = 1'b1;
			if (resp_valid_out === 1'b1) last_ans = resp_data_out;
			if (cmd_reject_out === 1'b1) rj = 1'b1;
			@(negedge clk_sys_in);
		end
		n_compared++;
		if (ok !== eok || rj !== erj) begin
			n_mismatch++;
			$display("[ERR] %0t code %h ans %b rej %b", $time, c, ok, rj);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #5 clk_sys_in = ~clk_sys_in;
	// whole run is about 110 cycles
	initial begin
		repeat (2000) @(posedge clk_sys_in);
		n_mismatch++;
		results();
	end
	initial begin
		for (int i = 0; i < 11; i++) otp_data_in[i*10 +: 10] = {8'(8'h11 * (i + 1)), 2'(i / 2)};
		repeat (20) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		rd(8'h73, 1'b0, 8'h00, 1'b1, 1'b0);
		$display("test blank end");
		otp_load_in = 1'b1;
		@(negedge clk_sys_in);
		otp_load_in = 1'b0;
		for (int k = 0; k < 5; k++)
			rd(8'h72 + 8'(k), 1'b0, exp_t[k], 1'b1, 1'b0);
		for (int k = 5; k < 10; k++)
			rd(8'h72 + 8'(k), 1'b0, exp_t[k], 1'b1, 1'b0);
		$display("test reads end");
		rd(8'h75, 1'b0, exp_t[3], 1'b1, 1'b0);
		low_ans = last_ans;
		rd(8'h76, 1'b0, exp_t[4], 1'b1, 1'b0);
		n_compared++;
		if (u_host.join_coord(last_ans, low_ans[7:6]) !== otp_data_in[30 +: 10]) begin
			n_mismatch++;
			$display("[ERR] %0t red x rebuild mismatch", $time);
		end
		$display("test rebuild end");
		rd(8'h74, 1'b1, 8'h00, 1'b0, 1'b1);
		partial_mode_in = 1'b1;
		rd(8'h76, 1'b0, 8'h00, 1'b0, 1'b1);
		partial_mode_in = 1'b0;
		rd(8'h71, 1'b0, 8'h00, 1'b0, 1'b0);
		$display("test refusals end");
		rst_n_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		rd(8'h7A, 1'b0, exp_t[8], 1'b1, 1'b0);
		$display("test reset end");
		results();
	end
endmodule // testbench
